// ### hw/scd_cfg.svh
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// Divider chain width, one stage per divided output
`define SCD_STAGES 3
// Pin synchroniser width: clock true, clock complement, enable_n, reset
`define SCD_PINS 4
`define SCD_PIN_CLK_T 0
`define SCD_PIN_CLK_C 1
`define SCD_PIN_EN_N 2
`define SCD_PIN_RST 3
// Open-pin default of every sampled pin
`define SCD_PIN_RESET 4'h0
// Common divider state after a divider reset
`define SCD_CNT_RESET 3'h0
// Clock rate of mclk_i
`define SCD_MCLK_MHZ 200

`endif

// ### hw/scd_pkg.sv
package scd_pkg;

	// Divider run state as latched on a falling input edge
	typedef enum logic {
		scd_run,
		scd_hold
	} scd_run_type;

	typedef logic [2:0] scd_cnt_type;

endpackage : scd_pkg

// ### hw/scd_sync_clock_divider.sv
`include "scd_cfg.svh"

module scd_sync_clock_divider
	import scd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic clk_true_i,
	input wire logic clk_comp_i,
	input wire logic enable_n_i,
	input wire logic divider_sync_reset_i,
	output logic half_rate_out_o,
	output logic half_rate_out_n_o,
	output logic quarter_rate_out_o,
	output logic quarter_rate_out_n_o,
	output logic eighth_rate_out_o,
	output logic eighth_rate_out_n_o,
	output logic phase_known_o
);

	////////////////////////////////////////////////////////////////////////////
	// Edge decode shared by rise and fall detection
	function automatic logic scd_edge(input logic prev, input logic cur, input logic rise);
		scd_edge = rise ? (cur & ~prev) : (prev & ~cur);
	endfunction : scd_edge

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [`SCD_PINS-1:0] sync1_r;
	logic [`SCD_PINS-1:0] sync2_r;
	logic clk_lvl_r;
	logic clk_lvl_nxt;
	logic clk_prev_r;
	scd_run_type run_r;
	scd_run_type run_nxt;
	scd_cnt_type cnt_r;
	scd_cnt_type cnt_nxt;
	scd_cnt_type cnt_n_r;
	scd_cnt_type cnt_n_nxt;
	logic known_r;
	logic known_nxt;
	logic clk_rise;
	logic clk_fall;
	logic clk_t;
	logic clk_c;
	logic [`SCD_PINS-1:0] sync1_nxt;
	logic [`SCD_PINS-1:0] sync2_nxt;
	logic clk_prev_nxt;
	logic rst_lvl;
	logic en_n_lvl;
	logic advance;
	logic [`SCD_STAGES-1:0] carry;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	////////////////////////////////////////////////////////////////////////////

	// Raw pins into first stage, first stage into second
	always_comb begin
		sync1_nxt = {divider_sync_reset_i, enable_n_i, clk_comp_i, clk_true_i};
		sync2_nxt = sync1_r; // Only reader of the first stage
	end

	// Two flops per pin, reset to open-pin level
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_r <= `SCD_PIN_RESET;
			sync2_r <= `SCD_PIN_RESET;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// Settled pin levels, all from the second stage
	assign clk_t = sync2_r[`SCD_PIN_CLK_T];
	assign clk_c = sync2_r[`SCD_PIN_CLK_C];
	assign en_n_lvl = sync2_r[`SCD_PIN_EN_N];
	assign rst_lvl = sync2_r[`SCD_PIN_RST];

	////////////////////////////////////////////////////////////////////////////
	// Internal clock level
	////////////////////////////////////////////////////////////////////////////

	// Differential decode, equal legs keep last level
	always_comb begin
		clk_lvl_nxt = clk_lvl_r;
		if (clk_t & ~clk_c) begin
			clk_lvl_nxt = 1'b1;
		end else if (~clk_t & clk_c) begin
			clk_lvl_nxt = 1'b0;
		end
		clk_prev_nxt = clk_lvl_r; // One cycle of history
	end

	// Level and history flops, reset to idle low
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_lvl_r <= 1'b0;
			clk_prev_r <= 1'b0;
		end else begin
			clk_lvl_r <= clk_lvl_nxt;
			clk_prev_r <= clk_prev_nxt;
		end
	end

	// One-cycle rise and fall strobes
	assign clk_rise = scd_edge(clk_prev_r, clk_lvl_r, 1'b1);
	assign clk_fall = scd_edge(clk_prev_r, clk_lvl_r, 1'b0);

	////////////////////////////////////////////////////////////////////////////
	// Enable latch
	////////////////////////////////////////////////////////////////////////////

	// Taken only at a fall, so no runt internal pulse
	always_comb begin
		run_nxt = run_r;
		if (clk_fall) begin
			run_nxt = en_n_lvl ? scd_hold : scd_run;
		end
	end

	// Latch flop, open enable means divide
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_r <= scd_run;
		end else begin
			run_r <= run_nxt;
		end
	end

	// Advance strobe, rise while running and out of reset
	always_comb begin
		advance = 1'b0;
		case (run_r)
			scd_run: begin
				advance = clk_rise & ~rst_lvl;
			end
			scd_hold: begin
				advance = 1'b0;
			end
			default: begin
				advance = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Divider stages
	////////////////////////////////////////////////////////////////////////////

	// Carry chain, stage toggles when all lower stages high
	assign carry[0] = advance;
	for (genvar i = 1; i < `SCD_STAGES; i++) begin : g_stage
		assign carry[i] = carry[i-1] & cnt_r[i-1];
	end

	// Next value of every stage in one place
	always_comb begin
		cnt_nxt = cnt_r ^ carry;
		if (rst_lvl) begin
			cnt_nxt = `SCD_CNT_RESET;
		end
		cnt_n_nxt = ~cnt_nxt;
	end

	// Stage flops, true and complement on one mclk edge
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= `SCD_CNT_RESET;
			cnt_n_r <= ~`SCD_CNT_RESET;
		end else begin
			cnt_r <= cnt_nxt;
			cnt_n_r <= cnt_n_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase-known flag
	////////////////////////////////////////////////////////////////////////////

	// Sticky once a divider reset is seen
	always_comb begin
		known_nxt = known_r;
		if (rst_lvl) begin
			known_nxt = 1'b1;
		end
	end

	// Flag flop, cleared only by rstn_i
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			known_r <= 1'b0;
		end else begin
			known_r <= known_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////////////

	// Straight from the stage flops
	assign half_rate_out_o = cnt_r[0];
	assign quarter_rate_out_o = cnt_r[1];
	assign eighth_rate_out_o = cnt_r[2];
	assign half_rate_out_n_o = cnt_n_r[0];
	assign quarter_rate_out_n_o = cnt_n_r[1];
	assign eighth_rate_out_n_o = cnt_n_r[2];
	assign phase_known_o = known_r;

endmodule : scd_sync_clock_divider

// ### dv/scd_sync_clock_divider_asserts.sv
module scd_chk(input wire logic mclk_i, rstn_i, enable_n_i, divider_sync_reset_i,
	half_rate_out_o, half_rate_out_n_o, quarter_rate_out_o, quarter_rate_out_n_o,
	eighth_rate_out_o, eighth_rate_out_n_o);
	timeunit 1ns;
	timeprecision 100ps;
	// Counter view of the true outputs
	wire [2:0] c = {eighth_rate_out_o, quarter_rate_out_o, half_rate_out_o};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// Pairs, reset, stage order, hold and run
	half_pair_a: assert property (half_rate_out_n_o != half_rate_out_o) else $error("pair");
	qtr_pair_a: assert property (quarter_rate_out_n_o != quarter_rate_out_o) else $error("pair");
	eig_pair_a: assert property (eighth_rate_out_n_o != eighth_rate_out_o) else $error("pair");
	rst_force_a: assert property (divider_sync_reset_i[*4] |-> c == 3'h0) else $error("rst");
	qtr_step_a: assert property ($changed(c[1]) && !divider_sync_reset_i |-> $fell(c[0]))
		else $error("qtr");
	eig_step_a: assert property ($changed(c[2]) && !divider_sync_reset_i |-> $fell(c[1]))
		else $error("eig");
	out_hold_a: assert property (enable_n_i[*8] ##1 enable_n_i[*4] |-> $stable(c)) else $error("hold");
	out_run_a: assert property ((!enable_n_i && !divider_sync_reset_i)[*8] |-> ##[0:12] $changed(c[0]))
		else $error("run");
endmodule : scd_chk
bind scd_sync_clock_divider scd_chk u_chk(.*);

// ### dv/scd_clk_src.sv
module scd_clk_src(input wire logic mclk_i, output logic clk_t_o = 1'h0, output logic clk_c_o);
	timeunit 1ns;
	timeprecision 100ps;
	int n = 0;
	// Three mclk cycles per phase, legs always opposite
	always @(negedge mclk_i) if (++n % 3 == 0) clk_t_o <= !clk_t_o;
	assign clk_c_o = !clk_t_o;
endmodule : scd_clk_src

// ### dv/tb_sync_clock_divider_2_4_8.sv
module tb_sync_clock_divider_2_4_8;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i = 0, rstn_i = 0, en_n = 0, dsr = 0;
	logic ct, cc, h, hn, q, qn, e, en, pk;
	int err_total = 0, checks_done = 0;
	wire [5:0] o = {e, en, q, qn, h, hn};
	// Clock, source and design
	initial forever #2.5 mclk_i = !mclk_i;
	scd_clk_src src(.mclk_i, .clk_t_o(ct), .clk_c_o(cc));
	scd_sync_clock_divider dut(.mclk_i, .rstn_i, .clk_true_i(ct), .clk_comp_i(cc),
		.enable_n_i(en_n), .divider_sync_reset_i(dsr), .half_rate_out_o(h),
		.half_rate_out_n_o(hn), .quarter_rate_out_o(q), .quarter_rate_out_n_o(qn),
		.eighth_rate_out_o(e), .eighth_rate_out_n_o(en), .phase_known_o(pk));
	function automatic logic [5:0] f(logic [2:0] c);
		return {c[2], !c[2], c[1], !c[1], c[0], !c[0]};
	endfunction : f
	task automatic chk(input logic [5:0] g, x);
		checks_done++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	// Divider reset, then a full cycle of eight advances
	task automatic t_div;
		@(negedge mclk_i) dsr = 1;
		repeat (10) @(negedge mclk_i);
		chk(o, f(3'h0));
		dsr = 0;
		@(posedge h);
		for (int k = 1; k <= 8; k++) begin
			@(negedge mclk_i);
			chk(o, f(k[2:0]));
			repeat (5) @(negedge mclk_i);
		end
		$display("div test done");
	endtask : t_div
	// Disable while input clock high, hold, then resume
	task automatic t_hold;
		logic [5:0] v;
		@(posedge ct);
		@(negedge mclk_i) en_n = 1;
		repeat (20) @(negedge mclk_i);
		v = o;
		repeat (30) @(negedge mclk_i);
		chk(o, v);
		en_n = 0;
		repeat (20) @(negedge mclk_i);
		chk({5'h0, o !== v}, 6'h01);
		$display("hold test done");
	endtask : t_hold
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		repeat (8) @(negedge mclk_i);
		rstn_i = 1;
		@(negedge mclk_i);
		chk({5'h0, pk}, 6'h00);
		t_div;
		chk({5'h0, pk}, 6'h01);
		t_hold;
		t_div;
		tally_and_finish;
	end
	// Watchdog
	initial begin
		#5us;
		err_total++;
		tally_and_finish;
	end
endmodule : tb_sync_clock_divider_2_4_8
